/* lso_pkg.sv */
package lso_pkg;

  // ************************************
  // clock and timing
  // ************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int SHOW_FN_MS = 2000;
  localparam int DEB_MS = 20;
  localparam logic [14:0] SHOW_FN_TICKS = 15'(SHOW_FN_MS / TICK_MS);
  localparam logic [14:0] DEB_TICKS = 15'(DEB_MS / TICK_MS);

  // ************************************
  // signal strength and bar
  // ************************************
  localparam int STR_W = 12;
  localparam int NLED = 10;
  localparam logic [11:0] STR_FULL = 12'hFFF;
  localparam logic [11:0] BAR_STEP = 12'h174;
  localparam logic [3:0] RISE_LVL = 4'h6;
  localparam logic [3:0] FALL_LVL = 4'h4;
  localparam logic [12:0] SENS_STEP = 13'h0040;
  localparam logic [12:0] SENS_MAX = 13'h0FFF;
  localparam logic [3:0] IDX_MAX = 4'hA;
  localparam logic [1:0] HYST_MAX = 2'h3;

  // ************************************
  // selector positions
  // ************************************
  localparam logic [3:0] POS_RUN = 4'h0;
  localparam logic [3:0] POS_CAL_FREE = 4'h1;
  localparam logic [3:0] POS_CAL_COV = 4'h2;
  localparam logic [3:0] POS_MAN_FREE = 4'h3;
  localparam logic [3:0] POS_MAN_COV = 4'h4;
  localparam logic [3:0] POS_HYST = 4'h5;
  localparam logic [3:0] POS_POL = 4'h6;
  localparam logic [3:0] POS_ON_DLY = 4'h7;
  localparam logic [3:0] POS_OFF_DLY = 4'h8;
  localparam logic [3:0] POS_SIM = 4'h9;
  localparam logic [3:0] POS_DAMP = 4'hA;

  // ************************************
  // register map
  // ************************************
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_SENS = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] ADDR_LIVE = 12'h00C;

  typedef struct packed {
    logic [3:0] damp_idx;
    logic [3:0] off_idx;
    logic [3:0] on_idx;
    logic pol_max;
    logic [1:0] hyst_m1;
  } lso_cfg_t;

  typedef struct packed {
    lso_cfg_t cfg;
    logic [12:0] sens;
  } lso_rec_t;

  localparam lso_cfg_t CFG_RST = '{4'h0, 4'h0, 4'h0, 1'b1, 2'h0};
  localparam logic [12:0] SENS_RST = 13'h0000;

  // time table shared by delays and damping, in ms
  function automatic logic [14:0] lso_time_ms(input logic [3:0] idx);
    case (idx)
      4'h1: lso_time_ms = 15'h0064;
      4'h2: lso_time_ms = 15'h00C8;
      4'h3: lso_time_ms = 15'h012C;
      4'h4: lso_time_ms = 15'h01F4;
      4'h5: lso_time_ms = 15'h03E8;
      4'h6: lso_time_ms = 15'h07D0;
      4'h7: lso_time_ms = 15'h0BB8;
      4'h8: lso_time_ms = 15'h1388;
      4'h9: lso_time_ms = 15'h2710;
      4'hA: lso_time_ms = 15'h4E20;
      default: lso_time_ms = 15'h0000;
    endcase
  endfunction

endpackage

/* lso_top.sv */
`timescale 1ns/100ps
// Overview of operation
// - show function number two seconds, then value
// - hysteresis settable from one to four steps
// - rising switch point fixed at level six
// - falling point level four down to one
// - hysteresis never touches current output
// - hysteresis defaults to one step
// - polarity position: each press toggles safety mode
// - maximum safety is the default polarity
// - on and off delays from eleven choices
// - output changes after crossing held full delay
// - short dips under off delay keep uncovered
// - delays never touch current output
// - damping averages strength over selectable window
// - both buttons calibrate in automatic positions
// - covered calibration leaves all ten segments dark
// - manual positions step sensitivity up or down
// - new calibration discards earlier adjustments
// - position zero shows live strength again
// - only zero is run; settings apply immediately
// - settings stored when selector leaves function
// - damping also feeds switch and current outputs
module lso_top
  import lso_pkg::*;
#(
  parameter int CYC_PER_TICK = TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] sel_pos_pin,
  input wire logic btn_inc_n,
  input wire logic btn_dec_n,
  input wire logic [11:0] strength,
  input wire logic nv_ld,
  input wire lso_pkg::lso_rec_t nv_ld_rec,
  output logic nv_wr,
  output lso_pkg::lso_rec_t nv_rec,
  output logic sw_out,
  output logic [9:0] led_bar,
  output logic [11:0] cur_level
);
  import lso_pkg::*;

  // ************************************
  // helpers
  // ************************************
  function automatic logic [9:0] bar_leds(input logic [3:0] n);
    bar_leds = 10'((11'h001 << n) - 11'h001);
  endfunction

  function automatic logic [3:0] step_idx(input logic [3:0] v, input logic up);
    if (up) begin
      step_idx = (v < IDX_MAX) ? v + 4'h1 : IDX_MAX;
    end else begin
      step_idx = (v != 4'h0) ? v - 4'h1 : 4'h0;
    end
  endfunction

  function automatic logic [3:0] clamp_idx(input logic [3:0] v);
    clamp_idx = (v > IDX_MAX) ? IDX_MAX : v;
  endfunction

  // ************************************
  // millisecond tick
  // ************************************
  logic [31:0] tick_cnt_r;
  logic ms_tick_r;

  // one shared tick keeps every long time a small counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b0;
    end else if (tick_cnt_r >= 32'(CYC_PER_TICK - 1)) begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      ms_tick_r <= 1'b0;
    end
  end

  // ************************************
  // pin synchronisers
  // ************************************
  logic [5:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [5:0] pin_ok;
  logic [3:0] sel_r;

  // buttons inverted here so that 1 means pressed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      pin_s3_r <= 6'h00;
    end else begin
      pin_s1_r <= {~btn_dec_n, ~btn_inc_n, sel_pos_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_ok = ~(pin_s2_r ^ pin_s3_r);

  // selector takes a new position only when all bits agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= POS_RUN;
    end else if (&pin_ok[3:0]) begin
      sel_r <= pin_s3_r[3:0];
    end
  end

  // ************************************
  // button debounce
  // ************************************
  logic [1:0] btn_db_r, btn_q_r;
  logic ev_inc, ev_dec, ev_both;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_deb
      logic [14:0] deb_cnt_r;
      // level must hold a full debounce time before it counts
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          deb_cnt_r <= 15'h0;
          btn_db_r[gi] <= 1'b0;
        end else if (!pin_ok[4+gi] || pin_s3_r[4+gi] == btn_db_r[gi]) begin
          deb_cnt_r <= 15'h0;
        end else if (deb_cnt_r >= DEB_TICKS) begin
          deb_cnt_r <= 15'h0;
          btn_db_r[gi] <= pin_s3_r[4+gi];
        end else if (ms_tick_r) begin
          deb_cnt_r <= deb_cnt_r + 15'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_q_r <= 2'b00;
    end else begin
      btn_q_r <= btn_db_r;
    end
  end

  // a press while the other is held is a two-button event
  assign ev_both = (btn_db_r[0] & ~btn_q_r[0] & btn_db_r[1]) |
                   (btn_db_r[1] & ~btn_q_r[1] & btn_db_r[0]);
  assign ev_inc = btn_db_r[0] & ~btn_q_r[0] & ~btn_db_r[1];
  assign ev_dec = btn_db_r[1] & ~btn_q_r[1] & ~btn_db_r[0];

  // ************************************
  // configuration record
  // ************************************
  lso_cfg_t cfg_r;
  logic [12:0] sens_r;
  logic [15:0] avg_r;
  logic apb_wr;
  logic [12:0] sens_up, sens_dn;

  assign apb_wr = psel & penable & pready & pwrite;

  // saturate manual steps so the offset never wraps
  assign sens_up = ($signed(sens_r) > $signed(SENS_MAX - SENS_STEP)) ?
                   SENS_MAX : sens_r + SENS_STEP;
  assign sens_dn = ($signed(sens_r) < $signed(SENS_STEP - SENS_MAX)) ?
                   13'(-SENS_MAX) : sens_r - SENS_STEP;

  // buttons act on the selected position; changes take effect at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RST;
      sens_r <= SENS_RST;
    end else if (nv_ld) begin
      cfg_r <= nv_ld_rec.cfg;
      sens_r <= nv_ld_rec.sens;
    end else if (apb_wr && paddr == ADDR_CFG) begin
      cfg_r.hyst_m1 <= pwdata[1:0];
      cfg_r.pol_max <= pwdata[2];
      cfg_r.on_idx <= clamp_idx(pwdata[7:4]);
      cfg_r.off_idx <= clamp_idx(pwdata[11:8]);
      cfg_r.damp_idx <= clamp_idx(pwdata[15:12]);
    end else if (apb_wr && paddr == ADDR_SENS) begin
      sens_r <= pwdata[12:0];
    end else begin
      case (sel_r)
        POS_CAL_FREE: begin
          if (ev_both) begin
            sens_r <= {1'b0, STR_FULL} - {1'b0, avg_r[15:4]};
          end
        end
        POS_CAL_COV: begin
          if (ev_both) begin
            sens_r <= 13'h0 - {1'b0, avg_r[15:4]};
          end
        end
        POS_MAN_FREE, POS_MAN_COV: begin
          if (ev_inc) begin
            sens_r <= sens_up;
          end else if (ev_dec) begin
            sens_r <= sens_dn;
          end
        end
        POS_HYST: begin
          if (ev_inc && cfg_r.hyst_m1 != HYST_MAX) begin
            cfg_r.hyst_m1 <= cfg_r.hyst_m1 + 2'h1;
          end else if (ev_dec && cfg_r.hyst_m1 != 2'h0) begin
            cfg_r.hyst_m1 <= cfg_r.hyst_m1 - 2'h1;
          end
        end
        POS_POL: begin
          if (ev_inc || ev_dec) begin
            cfg_r.pol_max <= ~cfg_r.pol_max;
          end
        end
        POS_ON_DLY: begin
          if (ev_inc || ev_dec) begin
            cfg_r.on_idx <= step_idx(cfg_r.on_idx, ev_inc);
          end
        end
        POS_OFF_DLY: begin
          if (ev_inc || ev_dec) begin
            cfg_r.off_idx <= step_idx(cfg_r.off_idx, ev_inc);
          end
        end
        POS_DAMP: begin
          if (ev_inc || ev_dec) begin
            cfg_r.damp_idx <= step_idx(cfg_r.damp_idx, ev_inc);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************
  // function display timing and commit
  // ************************************
  logic [3:0] sel_q_r;
  logic show_fn_r;
  logic [14:0] fn_cnt_r;

  // leaving a non-run position writes the whole record out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q_r <= POS_RUN;
      nv_wr <= 1'b0;
      nv_rec <= '0;
    end else begin
      sel_q_r <= sel_r;
      nv_wr <= (sel_r != sel_q_r) && (sel_q_r != POS_RUN);
      nv_rec <= '{cfg_r, sens_r};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      show_fn_r <= 1'b0;
      fn_cnt_r <= 15'h0;
    end else if (sel_r != sel_q_r) begin
      show_fn_r <= (sel_r != POS_RUN);
      fn_cnt_r <= 15'h0;
    end else if (show_fn_r && ms_tick_r) begin
      if (fn_cnt_r >= SHOW_FN_TICKS - 15'h1) begin
        show_fn_r <= 1'b0;
      end else begin
        fn_cnt_r <= fn_cnt_r + 15'h1;
      end
    end
  end

  // ************************************
  // damping filter
  // ************************************
  logic [14:0] dmp_cnt_r;
  logic [14:0] dmp_per;
  logic [16:0] dmp_diff;

  // first order average, 16 steps per window; 12.4 fixed point
  assign dmp_per = (lso_time_ms(cfg_r.damp_idx) >> 4);
  assign dmp_diff = {1'b0, strength, 4'h0} - {1'b0, avg_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_r <= 16'h0;
      dmp_cnt_r <= 15'h0;
    end else if (cfg_r.damp_idx == 4'h0) begin
      avg_r <= {strength, 4'h0};
      dmp_cnt_r <= 15'h0;
    end else if (ms_tick_r) begin
      if (dmp_cnt_r >= dmp_per) begin
        dmp_cnt_r <= 15'h0;
        avg_r <= avg_r + 16'($signed(dmp_diff) >>> 4);
      end else begin
        dmp_cnt_r <= dmp_cnt_r + 15'h1;
      end
    end
  end

  // ************************************
  // sensitivity and bar level
  // ************************************
  logic [13:0] adj_sum;
  logic [11:0] adj;
  logic [3:0] level;
  logic [11:0] thr;

  assign adj_sum = {2'b00, avg_r[15:4]} + {sens_r[12], sens_r};
  assign adj = adj_sum[13] ? 12'h000 : (adj_sum[12] ? STR_FULL : adj_sum[11:0]);

  // count thresholds passed: ten equal bar steps
  always_comb begin
    level = 4'h0;
    thr = 12'h000;
    for (int k = 0; k < NLED; k++) begin
      thr = thr + BAR_STEP;
      if (adj >= thr) begin
        level = level + 4'h1;
      end
    end
  end

  // ************************************
  // limit detection with hysteresis
  // ************************************
  logic above_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      above_r <= 1'b0;
    end else if (level >= RISE_LVL) begin
      above_r <= 1'b1;
    end else if (level <= FALL_LVL - {2'b00, cfg_r.hyst_m1}) begin
      above_r <= 1'b0;
    end
  end

  // ************************************
  // switching delays
  // ************************************
  logic det_r;
  logic [14:0] dly_cnt_r;
  logic [14:0] dly_tgt;

  assign dly_tgt = above_r ? lso_time_ms(cfg_r.on_idx) : lso_time_ms(cfg_r.off_idx);

  // counter restarts whenever the crossing lapses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_r <= 1'b0;
      dly_cnt_r <= 15'h0;
    end else if (above_r == det_r) begin
      dly_cnt_r <= 15'h0;
    end else if (dly_cnt_r >= dly_tgt) begin
      det_r <= above_r;
      dly_cnt_r <= 15'h0;
    end else if (ms_tick_r) begin
      dly_cnt_r <= dly_cnt_r + 15'h1;
    end
  end

  // ************************************
  // outputs
  // ************************************
  // maximum safety energises on free path, so supply loss reads covered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_out <= 1'b0;
      cur_level <= 12'h000;
    end else begin
      sw_out <= cfg_r.pol_max ? det_r : ~det_r;
      cur_level <= adj;
    end
  end

  // bar shows live level only in run, calibration, manual and simulation positions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_bar <= 10'h000;
    end else if (show_fn_r) begin
      led_bar <= {6'h00, sel_r};
    end else begin
      case (sel_r)
        POS_RUN, POS_CAL_FREE, POS_CAL_COV,
        POS_MAN_FREE, POS_MAN_COV, POS_SIM: begin
          led_bar <= bar_leds(level);
        end
        POS_HYST: led_bar <= bar_leds({2'b00, cfg_r.hyst_m1} + 4'h1);
        POS_POL: led_bar <= cfg_r.pol_max ? 10'h002 : 10'h001;
        POS_ON_DLY: led_bar <= bar_leds(cfg_r.on_idx);
        POS_OFF_DLY: led_bar <= bar_leds(cfg_r.off_idx);
        POS_DAMP: led_bar <= bar_leds(cfg_r.damp_idx);
        default: led_bar <= 10'h000;
      endcase
    end
  end

  // ************************************
  // apb slave
  // ************************************
  logic [31:0] rd_val;
  logic rd_err;

  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    case (paddr)
      ADDR_CFG: rd_val = {16'h0, cfg_r.damp_idx, cfg_r.off_idx, cfg_r.on_idx,
                          1'b0, cfg_r.pol_max, cfg_r.hyst_m1};
      ADDR_SENS: rd_val = {19'h0, sens_r};
      ADDR_STAT: rd_val = {19'h0, show_fn_r, sel_r, sw_out, det_r,
                           above_r, 1'b0, level};
      ADDR_LIVE: rd_val = {20'h0, adj};
      default: rd_err = 1'b1;
    endcase
  end

  // answer prepared in setup, so access completes with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= rd_err;
      prdata <= pwrite ? 32'h0 : rd_val;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

endmodule

/* lso_top_checker.sv */
`timescale 1ns/100ps
// ************************************
// port-level checks of the switch block
// ************************************
module lso_chk
  import lso_pkg::*;
#(
  parameter int CYC_PER_TICK = TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nv_wr,
  input wire logic sw_out,
  input wire logic [9:0] led_bar
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (psel && !penable && paddr > 12'h00C
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && !penable && paddr <= 12'h00C && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("mapped access refused");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  commit_pulse_a: assert property (nv_wr |=> !nv_wr)
    else $error("commit pulse too long");
  reset_quiet_a: assert property ($rose(presetn) |-> !sw_out && !nv_wr && led_bar == 10'h000)
    else $error("outputs not quiet after reset");
endmodule

bind lso_top lso_chk #(.CYC_PER_TICK(CYC_PER_TICK)) chk_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nv_wr(nv_wr),
  .sw_out(sw_out), .led_bar(led_bar)
);

/* lso_pcs_model.sv */
`timescale 1ns/100ps
// ************************************
// downstream control system reading the switch
// ************************************
module lso_pcs_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sw_out,
  output int sw_count
);
  logic last_r;

  // counts every switching of the output, so chatter shows up as extra counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= 1'b0;
      sw_count <= 0;
    end else begin
      last_r <= sw_out;
      if (sw_out !== last_r) begin
        sw_count <= sw_count + 1;
      end
    end
  end
endmodule

/* lso_top_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ************************************
// bench of the switch-output block
// ************************************
module lso_top_tb;
  import lso_pkg::*;
  localparam int CPT = 10; // 1 ms = 10 cycles keeps the run short
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nv_ld, nv_wr, sw_out;
  logic btn_inc_n, btn_dec_n, err;
  logic [11:0] paddr, strength, cur_level;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] sel_pos_pin;
  logic [9:0] led_bar;
  lso_rec_t nv_ld_rec, nv_rec, rec;
  int num_errors = 0;
  int checked = 0;
  int sw_count, h, d, k, nw;

  lso_top #(.CYC_PER_TICK(CPT)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sel_pos_pin(sel_pos_pin), .btn_inc_n(btn_inc_n), .btn_dec_n(btn_dec_n),
    .strength(strength), .nv_ld(nv_ld), .nv_ld_rec(nv_ld_rec), .nv_wr(nv_wr),
    .nv_rec(nv_rec), .sw_out(sw_out), .led_bar(led_bar), .cur_level(cur_level)
  );
  lso_pcs_model pcs (.pclk(pclk), .presetn(presetn), .sw_out(sw_out), .sw_count(sw_count));

  // free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // a random strength inside bar level l
  function automatic logic [11:0] at_lvl(input int l);
    at_lvl = 12'(l * int'(BAR_STEP) + $urandom_range(371, 0));
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; waits for pready as long as it takes, the watchdog ends a hang
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lvl(input int l, input int n);
    @(posedge pclk) strength <= at_lvl(l);
    wt(n);
  endtask

  // held well past the 20 ms debounce, released just as long
  task automatic press(input logic i, input logic dn);
    @(posedge pclk);
    btn_inc_n <= ~i;
    btn_dec_n <= ~dn;
    wt(40 * CPT);
    btn_inc_n <= 1'b1;
    btn_dec_n <= 1'b1;
    wt(40 * CPT);
  endtask

  // moves the selector and catches any commit pulse on the way
  task automatic pos(input logic [3:0] p);
    nw = 0;
    @(posedge pclk) sel_pos_pin <= p;
    repeat (12) begin
      @(posedge pclk);
      if (nv_wr === 1'b1) begin
        nw++;
        rec = nv_rec;
      end
    end
  endtask

  task finish_test;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog sized well above the ~50k cycles the tests need
  initial begin
    wt(100000);
    num_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test;
  end

  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    sel_pos_pin = POS_RUN; btn_inc_n = 1'b1; btn_dec_n = 1'b1; strength = '0;
    nv_ld = 1'b0; nv_ld_rec = '0;
    void'($urandom(53923));
    wt(8);
    presetn <= 1'b1;
    apb(ADDR_CFG, 1'b0, 32'h0);
    `CHK(rd, 32'h4);
    apb(ADDR_SENS, 1'b0, 32'h0);
    `CHK(rd, 32'h0);
    apb(12'h010, 1'b0, 32'h0);
    `CHK(err, 1'b1);
    $display("test reset done");
    // every hysteresis setting against both switch points
    for (h = 0; h < 4; h++) begin
      apb(ADDR_CFG, 1'b1, 32'(4 + h));
      lvl(0, 10); `CHK(sw_out, 1'b0);
      lvl(5, 10); `CHK(sw_out, 1'b0);
      `CHK(cur_level, strength);
      lvl(6, 10); `CHK(sw_out, 1'b1);
      lvl(5 - h, 10); `CHK(sw_out, 1'b1);
      lvl(4 - h, 10); `CHK(sw_out, 1'b0);
    end
    $display("test hysteresis done");
    apb(ADDR_CFG, 1'b1, 32'h0);
    lvl(8, 10); `CHK(sw_out, 1'b0);
    lvl(0, 10); `CHK(sw_out, 1'b1);
    $display("test polarity done");
    // delays: 100, 200 or 300 ms, a dip shorter than the off delay
    d = $urandom_range(3, 1);
    apb(ADDR_CFG, 1'b1, 32'h4 | (d << 8) | (d << 4));
    lvl(0, 1000 * d + 20);
    k = sw_count;
    lvl(8, 1000 * d - 100); `CHK(sw_out, 1'b0);
    wt(200); `CHK(sw_out, 1'b1);
    lvl(2, $urandom_range(1000 * d - 200, 100));
    lvl(8, 1000 * d + 100); `CHK(sw_out, 1'b1);
    `CHK(sw_count, k + 1);
    lvl(2, 1000 * d + 100); `CHK(sw_out, 1'b0);
    `CHK(cur_level, strength);
    $display("test delays done");
    // damping: a dark-to-bright step creeps in, so the switch follows late
    apb(ADDR_CFG, 1'b1, 32'h1004);
    lvl(9, 20); `CHK(sw_out, 1'b0);
    `CHK(cur_level < strength, 1'b1);
    wt(8000); `CHK(sw_out, 1'b1);
    apb(ADDR_CFG, 1'b1, 32'h4);
    $display("test damping done");
    // selector display, buttons and commit on leaving a position
    pos(POS_HYST); `CHK(led_bar, 10'h005);
    `CHK(nw, 0);
    wt(SHOW_FN_MS * CPT); `CHK(led_bar, 10'h001);
    press(1'b1, 1'b0);
    apb(ADDR_CFG, 1'b0, 32'h0);
    `CHK(rd[1:0], 2'h1);
    pos(POS_POL); `CHK(nw, 1);
    `CHK(rec.cfg.hyst_m1, 2'h1);
    press(1'b0, 1'b1);
    apb(ADDR_CFG, 1'b0, 32'h0);
    `CHK(rd[2], 1'b0);
    press(1'b1, 1'b0);
    apb(ADDR_CFG, 1'b0, 32'h0);
    `CHK(rd[2], 1'b1);
    pos(POS_ON_DLY);
    press(1'b1, 1'b0);
    apb(ADDR_CFG, 1'b0, 32'h0);
    `CHK(rd[7:4], 4'h1);
    pos(POS_MAN_FREE);
    press(1'b1, 1'b0);
    apb(ADDR_SENS, 1'b0, 32'h0);
    `CHK(rd, 32'h40);
    press(1'b0, 1'b1);
    apb(ADDR_SENS, 1'b0, 32'h0);
    `CHK(rd, 32'h0);
    press(1'b1, 1'b0);
    $display("test buttons done");
    // covered calibration darkens the bar and replaces the manual step
    lvl(7, 2);
    pos(POS_CAL_COV);
    press(1'b1, 1'b1);
    apb(ADDR_LIVE, 1'b0, 32'h0);
    `CHK(rd, 32'h0);
    apb(ADDR_SENS, 1'b0, 32'h0);
    `CHK(rd[12:0], 13'(-int'(strength)));
    pos(POS_RUN); `CHK(nw, 1);
    `CHK(led_bar, 10'h000);
    $display("test calibration done");
    // restore path: the stored sensitivity comes back over a cleared one
    apb(ADDR_SENS, 1'b1, 32'h0);
    @(posedge pclk);
    nv_ld_rec <= rec;
    nv_ld <= 1'b1;
    @(posedge pclk);
    nv_ld <= 1'b0;
    apb(ADDR_SENS, 1'b0, 32'h0);
    `CHK(rd[12:0], rec.sens);
    $display("test restore done");
    finish_test;
  end
endmodule
